// ### logic/orr_defines.svh
// Widths, reset values and the zero flag position for the OR and return execution block.
// Assumes the decoder outside hands over one decoded operation code per instruction.
`ifndef ORR_DEFINES_SVH
`define ORR_DEFINES_SVH

`define ORR_DATA_W      8
`define ORR_PC_W        13
`define ORR_STAT_W      8
`define ORR_ZERO_BIT    2
`define ORR_WREG_RST    8'h00
`define ORR_STAT_RST    8'h00
`define ORR_GIE_RST     1'b0

`endif

// ### logic/orr_exec.sv
// Execution of the OR and return instruction group inside the CPU core.
// Assumes memory read data is valid in the cycle the instruction is valid,
// and the stack supplies its top entry combinationally on stack_top_i.
//
// What this block does
// (RULE1) OR memory into working register
// (RULE2) OR immediate into working register
// (RULE3) OR working register into memory only
// (RULE4) Return pops stack into program counter
// (RULE5) Return-immediate form also loads immediate into working register
// (RULE6) Interrupt return restores PC, sets enable
// (RULE7) Enable gates every interrupt
// (RULE8) Pending interrupt serviced before main program
// (RULE9) OR forms set zero flag only
// (RULE10) Returns leave status flags alone
`timescale 1ns/1ns
`default_nettype none
`include "orr_defines.svh"

module orr_exec (
	input  wire logic                        clock_i,
	input  wire logic                        sys_rst_i,
	input  wire orr_pkg::orr_instr_s         instr_i,
	input  wire logic [`ORR_DATA_W-1:0]      mem_rdata_i,
	input  wire logic [`ORR_PC_W-1:0]        stack_top_i,
	input  wire logic                        irq_pending_i,
	input  wire logic                        gie_clear_i,
	output orr_pkg::orr_memwr_s              mem_wr_o,
	output logic                             stack_pop_o,
	output logic                             pc_load_o,
	output logic [`ORR_PC_W-1:0]             pc_value_o,
	output logic                             irq_take_o,
	output logic [`ORR_DATA_W-1:0]           working_register_o,
	output logic [`ORR_STAT_W-1:0]           status_o,
	output logic                             global_interrupt_enable_o
);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	// Named selects per instruction form
	wire logic is_or_mem  = instr_i.valid && (instr_i.op == orr_pkg::ORR_OP_OR_MEM);
	wire logic is_or_imm  = instr_i.valid && (instr_i.op == orr_pkg::ORR_OP_OR_IMM);
	wire logic is_or_into = instr_i.valid && (instr_i.op == orr_pkg::ORR_OP_OR_INTO);
	wire logic is_ret     = instr_i.valid && (instr_i.op == orr_pkg::ORR_OP_RET);
	wire logic is_ret_imm = instr_i.valid && (instr_i.op == orr_pkg::ORR_OP_RET_IMM);
	wire logic is_ret_int = instr_i.valid && (instr_i.op == orr_pkg::ORR_OP_RET_INT);
	wire logic any_or     = is_or_mem || is_or_imm || is_or_into;
	wire logic any_ret    = is_ret || is_ret_imm || is_ret_int;

	logic [`ORR_DATA_W-1:0] wreg_q;
	logic [`ORR_DATA_W-1:0] wreg_d;
	logic [`ORR_STAT_W-1:0] stat_q;
	logic [`ORR_STAT_W-1:0] stat_d;
	logic                   gie_q;
	logic                   gie_d;
	logic                   irq_hold_q;
	logic                   irq_hold_d;
	orr_pkg::orr_memwr_s    memwr_q;
	logic [`ORR_DATA_W-1:0] or_b;
	logic [`ORR_DATA_W-1:0] or_y;
	logic                   or_zero;

	// ----------------------------------------
	// OR datapath
	// ----------------------------------------
	// Immediate form uses the instruction operand, the others memory
	assign or_b = is_or_imm ? instr_i.imm : mem_rdata_i;

	orr_or_unit u_or (
		.a_i    (wreg_q),
		.b_i    (or_b),
		.y_o    (or_y),
		.zero_o (or_zero)
	);

	// ----------------------------------------
	// Next-state selection
	// ----------------------------------------
	// (RULE1) (RULE2) Working register result
	// (RULE5) Return immediate load
	// (RULE3) Into-memory form keeps working register
	assign wreg_d = (is_or_mem || is_or_imm) ? or_y :
	                is_ret_imm               ? instr_i.imm : wreg_q;

	// (RULE9) Only the zero bit follows OR
	// (RULE10) Returns fall to hold path
	always_comb begin
		stat_d = stat_q;
		if (any_or) begin
			stat_d[`ORR_ZERO_BIT] = or_zero;
		end
	end

	// (RULE6) Interrupt return sets enable, winning over a clear
	assign gie_d = is_ret_int ? 1'b1 : (gie_clear_i ? 1'b0 : gie_q);

	// (RULE8) Hold the take request across the return so the routine runs first
	// The source may drop its pending level right after the return cycle; the held copy
	// still forces one take before the first fetch at the restored address
	assign irq_hold_d = is_ret_int && irq_pending_i;

	// ----------------------------------------
	// Control outputs
	// ----------------------------------------
	// (RULE4) Pop stack and redirect fetch
	// Target idles at zero so a stale stack top never reaches fetch
	assign stack_pop_o = any_ret;
	assign pc_load_o   = any_ret;
	assign pc_value_o  = any_ret ? stack_top_i : `ORR_PC_W'(0);

	// (RULE7) Enable gates interrupts; a held request from an interrupt return is taken next cycle
	assign irq_take_o = gie_q && (irq_pending_i || irq_hold_q);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Architectural state, kept short
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wreg_q     <= `ORR_WREG_RST;
			stat_q     <= `ORR_STAT_RST;
			gie_q      <= `ORR_GIE_RST;
			irq_hold_q <= 1'b0;
		end else begin
			wreg_q     <= wreg_d;
			stat_q     <= stat_d;
			gie_q      <= gie_d;
			irq_hold_q <= irq_hold_d;
		end
	end

	// (RULE3) Memory write of the OR result, registered
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			memwr_q <= '0;
		end else begin
			memwr_q.we    <= is_or_into;
			memwr_q.wdata <= is_or_into ? or_y : `ORR_DATA_W'(0);
		end
	end

	assign mem_wr_o                  = memwr_q;
	assign working_register_o        = wreg_q;
	assign status_o                  = stat_q;
	assign global_interrupt_enable_o = gie_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_or_mem_wreg: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE1
		is_or_mem |=> wreg_q == ($past(wreg_q) | $past(mem_rdata_i)))
		else $error("OR memory result wrong");

	chk_or_imm_wreg: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE2
		is_or_imm |=> wreg_q == ($past(wreg_q) | $past(instr_i.imm)))
		else $error("OR immediate result wrong");

	chk_or_into_mem: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE3
		is_or_into |=> mem_wr_o.we && $stable(wreg_q)
		&& mem_wr_o.wdata == ($past(wreg_q) | $past(mem_rdata_i)))
		else $error("OR into memory wrong");

	chk_ret_pc_load: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE4
		any_ret |-> pc_load_o && stack_pop_o && pc_value_o == stack_top_i)
		else $error("Return did not restore PC");

	chk_ret_imm_load: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE5
		is_ret_imm |=> wreg_q == $past(instr_i.imm))
		else $error("Return immediate not loaded");

	chk_intret_gie_set: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE6
		is_ret_int |=> global_interrupt_enable_o)
		else $error("Interrupt return left enable clear");

	chk_gie_gates_irq: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE7
		!global_interrupt_enable_o |-> !irq_take_o)
		else $error("Interrupt taken while disabled");

	chk_intret_pend_take: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE8
		is_ret_int && irq_pending_i |=> irq_take_o)
		else $error("Pending interrupt not taken after return");

	chk_or_zero_flag: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE9
		any_or |=> status_o[`ORR_ZERO_BIT] == (($past(wreg_q) | $past(or_b)) == 8'h00))
		else $error("Zero flag wrong after OR");

	chk_ret_flags_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE10
		any_ret |=> $stable(status_o))
		else $error("Return changed status");

	chk_memwr_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE3
		!is_or_into |=> !mem_wr_o.we)
		else $error("Memory write without OR into memory");

	chk_pop_only_ret: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE4
		!any_ret |-> !stack_pop_o && !pc_load_o && pc_value_o == `ORR_PC_W'(0))
		else $error("Stack popped outside a return");

	chk_ret_wreg_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE4
		is_ret |=> $stable(wreg_q))
		else $error("Plain return changed working register");

	chk_or_other_flags: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE9
		any_or |=> $stable({status_o[`ORR_STAT_W-1:`ORR_ZERO_BIT+1], status_o[`ORR_ZERO_BIT-1:0]}))
		else $error("OR changed a flag other than zero");

	chk_gie_clear_drop: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RULE7
		gie_clear_i && !is_ret_int |=> !global_interrupt_enable_o)
		else $error("Enable not cleared on request");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	cov_or_zero: cover property (@(posedge clock_i) disable iff (sys_rst_i) any_or && or_zero);
	cov_or_into: cover property (@(posedge clock_i) disable iff (sys_rst_i) is_or_into);
	cov_ret_plain: cover property (@(posedge clock_i) disable iff (sys_rst_i) is_ret);
	cov_ret_imm: cover property (@(posedge clock_i) disable iff (sys_rst_i) is_ret_imm);
	cov_intret_pend: cover property (@(posedge clock_i) disable iff (sys_rst_i) is_ret_int && irq_pending_i);

endmodule : orr_exec

`default_nettype wire

// ### logic/orr_or_unit.sv
// Bitwise OR datapath with zero detection.
// Assumes purely combinational use inside the execution block.
`timescale 1ns/1ns
`default_nettype none
`include "orr_defines.svh"

module orr_or_unit (
	input  wire logic [`ORR_DATA_W-1:0] a_i,
	input  wire logic [`ORR_DATA_W-1:0] b_i,
	output logic      [`ORR_DATA_W-1:0] y_o,
	output logic                        zero_o
);

	// OR result and zero flag
	assign y_o    = a_i | b_i;
	assign zero_o = (y_o == `ORR_DATA_W'(0));

endmodule : orr_or_unit

`default_nettype wire

// ### logic/orr_pkg.sv
// Types for the OR and return execution block.
// Assumes orr_defines.svh is on the include path.
`include "orr_defines.svh"

package orr_pkg;

	typedef enum logic [2:0] {
		ORR_OP_NONE      = 3'h0,
		ORR_OP_OR_MEM    = 3'h1,
		ORR_OP_OR_IMM    = 3'h2,
		ORR_OP_OR_INTO   = 3'h3,
		ORR_OP_RET       = 3'h4,
		ORR_OP_RET_IMM   = 3'h5,
		ORR_OP_RET_INT   = 3'h6
	} orr_op_e;

	// One decoded instruction from the fetch/decode stage
	typedef struct packed {
		logic                         valid;
		orr_op_e                      op;
		logic [`ORR_DATA_W-1:0]       imm;
	} orr_instr_s;

	// Data memory write request
	typedef struct packed {
		logic                         we;
		logic [`ORR_DATA_W-1:0]       wdata;
	} orr_memwr_s;

endpackage : orr_pkg

// ### testbench/orr_exec_test.sv
// Self-checking bench for the OR and return execution block.
// Assumes orr_pkg is compiled first and orr_defines.svh is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "orr_defines.svh"

module orr_exec_test;
	logic                    clock_i;
	logic                    sys_rst_i;
	orr_pkg::orr_instr_s     instr_i;
	logic [7:0]              mem_rdata_i;
	logic [12:0]             stack_top_i;
	logic                    irq_pending_i;
	logic                    gie_clear_i;
	orr_pkg::orr_memwr_s     mem_wr_o;
	logic                    stack_pop_o;
	logic                    pc_load_o;
	logic [12:0]             pc_value_o;
	logic                    irq_take_o;
	logic [7:0]              working_register_o;
	logic [7:0]              status_o;
	logic                    global_interrupt_enable_o;
	int                      n_errors = 0;
	int                      num_checks = 0;

	orr_exec orr_exec_inst (
		.clock_i                   (clock_i),
		.sys_rst_i                 (sys_rst_i),
		.instr_i                   (instr_i),
		.mem_rdata_i               (mem_rdata_i),
		.stack_top_i               (stack_top_i),
		.irq_pending_i             (irq_pending_i),
		.gie_clear_i               (gie_clear_i),
		.mem_wr_o                  (mem_wr_o),
		.stack_pop_o               (stack_pop_o),
		.pc_load_o                 (pc_load_o),
		.pc_value_o                (pc_value_o),
		.irq_take_o                (irq_take_o),
		.working_register_o        (working_register_o),
		.status_o                  (status_o),
		.global_interrupt_enable_o (global_interrupt_enable_o)
	);

	// 250 MHz core clock
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	// Single compare task; narrower results are zero-extended
	task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test

	// Present one instruction; combinational answers are settled 1 ns later
	task automatic issue(input orr_pkg::orr_op_e op, input logic [7:0] imm, input logic [7:0] mem);
		@(posedge clock_i);
		instr_i <= '{1'b1, op, imm};
		mem_rdata_i <= mem;
		#1;
	endtask : issue

	// Drop the instruction; registered answers of the taken edge are visible after it
	task automatic settle;
		@(posedge clock_i);
		instr_i <= '0;
		#1;
	endtask : settle

	task automatic t_or;
		issue(orr_pkg::ORR_OP_OR_IMM, 8'h00, 8'hff); settle;
		chk("wreg", 13'h0000, working_register_o);
		chk("status", 13'h0004, status_o);
		issue(orr_pkg::ORR_OP_OR_IMM, 8'h5a, 8'hff); settle;
		chk("wreg", 13'h005a, working_register_o);
		chk("status", 13'h0000, status_o);
		issue(orr_pkg::ORR_OP_OR_MEM, 8'hff, 8'h81); settle;
		chk("wreg", 13'h00db, working_register_o);
		issue(orr_pkg::ORR_OP_OR_INTO, 8'h00, 8'h24); settle;
		chk("mem we", 13'h0001, mem_wr_o.we);
		chk("mem wdata", 13'h00ff, mem_wr_o.wdata);
		chk("wreg", 13'h00db, working_register_o);
		chk("status", 13'h0000, status_o);
		settle;
		chk("mem we", 13'h0000, mem_wr_o.we);
		$display("or tests done");
	endtask : t_or

	task automatic t_ret;
		@(posedge clock_i);
		stack_top_i <= 13'h1abc;
		issue(orr_pkg::ORR_OP_RET, 8'h00, 8'h00);
		chk("pop", 13'h0001, stack_pop_o);
		chk("pc load", 13'h0001, pc_load_o);
		chk("pc", 13'h1abc, pc_value_o);
		settle;
		chk("wreg", 13'h00db, working_register_o);
		chk("pop idle", 13'h0000, stack_pop_o);
		chk("pc idle", 13'h0000, pc_value_o);
		issue(orr_pkg::ORR_OP_RET_IMM, 8'h00, 8'hff);
		chk("pc", 13'h1abc, pc_value_o);
		settle;
		chk("wreg", 13'h0000, working_register_o);
		chk("status", 13'h0000, status_o);
		$display("return tests done");
	endtask : t_ret

	task automatic t_irq;
		@(posedge clock_i);
		irq_pending_i <= 1'b1;
		#1;
		chk("irq take", 13'h0000, irq_take_o);
		issue(orr_pkg::ORR_OP_OR_IMM, 8'h00, 8'h00); settle;
		chk("status", 13'h0004, status_o);
		issue(orr_pkg::ORR_OP_RET_INT, 8'h00, 8'h00);
		chk("pc", 13'h1abc, pc_value_o);
		// Pending drops with the return, so only the held request can raise the take
		@(posedge clock_i);
		instr_i <= '0;
		irq_pending_i <= 1'b0;
		#1;
		chk("gie", 13'h0001, global_interrupt_enable_o);
		chk("irq take", 13'h0001, irq_take_o);
		chk("status", 13'h0004, status_o);
		@(posedge clock_i);
		gie_clear_i <= 1'b1;
		irq_pending_i <= 1'b1;
		@(posedge clock_i);
		gie_clear_i <= 1'b0;
		#1;
		chk("irq take", 13'h0000, irq_take_o);
		$display("interrupt tests done");
	endtask : t_irq

	// Watchdog, well past the few dozen cycles the tests need
	initial begin
		#8000;
		n_errors++;
		end_of_test();
	end

	// Main sequence: 21-cycle reset, then the scenarios
	initial begin
		sys_rst_i = 1'b1;
		instr_i = '0;
		mem_rdata_i = 8'h00;
		stack_top_i = 13'h0000;
		irq_pending_i = 1'b0;
		gie_clear_i = 1'b0;
		repeat (20) @(posedge clock_i);
		#1;
		chk("reset wreg", 13'h0000, working_register_o);
		chk("reset gie", 13'h0000, global_interrupt_enable_o);
		@(posedge clock_i);
		sys_rst_i <= 1'b0;
		t_or();
		t_ret();
		t_irq();
		end_of_test();
	end
endmodule : orr_exec_test
`default_nettype wire
